// file: hw/twr_pkg.sv
// Shared constants, types and helpers for the two-wire read/address link.
// Assumes both ends run from one 25 MHz system clock with a synchronous reset.
package twr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int          CLK_PERIOD_NS = 40;   // System clock period
	localparam int          SCL_HALF_NS   = 160;  // Half period of the made link clock
	localparam int          SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;
	localparam int          SLOT_CYC      = 2 * SCL_HALF_CYC;
	localparam logic [2:0]  SLOT_LAST     = 3'(SLOT_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Address byte layout and pointer widths
	localparam int          MEM_AW    = 15;
	localparam int          RTC_AW    = 4;
	localparam logic [3:0]  ID_MEM    = 4'ha;
	localparam logic [3:0]  ID_RTC    = 4'hd;
	localparam int          RW_BIT    = 0;
	localparam int          CS_LSB    = 1;
	localparam int          ID_LSB    = 4;
	localparam logic [3:0]  RTC_TOP   = 4'h8;
	localparam logic [3:0]  BYTE_BITS = 4'h8;
	localparam logic [3:0]  LAST_BIT  = 4'h7;
	localparam logic [14:0] MEM_RST   = 15'h0000;
	localparam logic [3:0]  RTC_RST   = 4'h0;
	localparam logic [1:0]  FIFO_DEPTH = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// State and option encodings
	typedef enum logic [2:0] {
		D_IDLE = 3'b000, D_ADDR = 3'b001, D_AHI = 3'b010, D_ALO = 3'b011,
		D_WDAT = 3'b100, D_ACK = 3'b101, D_RD = 3'b110, D_RACK = 3'b111
	} twr_dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000, H_START = 3'b001, H_TX = 3'b010, H_RX = 3'b011, H_STOP = 3'b100
	} twr_host_state_t;

	typedef enum logic [2:0] {
		P_SW = 3'b000, P_AHI = 3'b001, P_ALO = 3'b010, P_SR = 3'b011, P_RX = 3'b100
	} twr_phase_t;

	typedef enum logic [1:0] {
		T_NACK_STOP = 2'b00, T_NACK_START = 2'b01, T_STOP9 = 2'b10, T_START9 = 2'b11
	} twr_term_t;

	////////////////////////////////////////////////////////////////////////////
	// Pointer advance: memory rolls 7fff to 0000, clock bank 8 to 0
	function automatic logic [MEM_AW-1:0] twr_mem_next(input logic [MEM_AW-1:0] a);
		twr_mem_next = a + 15'h0001;
	endfunction : twr_mem_next

	function automatic logic [RTC_AW-1:0] twr_rtc_next(input logic [RTC_AW-1:0] a);
		twr_rtc_next = (a >= RTC_TOP) ? RTC_RST : a + 4'h1;
	endfunction : twr_rtc_next

endpackage : twr_pkg

// file: hw/twr_if.sv
// Link between the bus master and the serial slave: clock and open-drain data.
// Assumes the master alone drives the clock; data has a pull-up.
`timescale 1ns/100ps
`default_nettype none

interface twr_if;
	logic scl;       // Link clock, push-pull from the master
	logic m_sda_o;   // Master data drive value
	logic m_sda_oe;  // Master drives data line
	logic s_sda_o;   // Slave data drive value
	logic s_sda_oe;  // Slave drives data line
	logic sda;       // Resolved line level

	// Wired-and with pull-up: low whenever an enabled end drives low
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
	modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : twr_if

`default_nettype wire

// file: hw/twr_dev.sv
// Serial slave end: address decode, address pointers, read shifting.
// Assumes the link pins are asynchronous and that fetch data follows
// fetch address within the same clock.
//
// Operation
// RQ1: Read address byte acked, shift data next clock
// RQ2: Current read starts at latched address
// RQ3: Advance address after every byte sent
// RQ4: Master ack fetches next sequential byte
// RQ5: Master may end: no-ack, then Stop
// RQ6: Master may end: no-ack, then Start
// RQ7: Stop or Start in ninth clock ends read
// RQ8: Acked bytes keep being driven out
// RQ9: Memory pointer wraps top to zero
// RQ10: Master loads address through write header
// RQ11: Start after address abandons write, read follows
// RQ12: Clock writes use one address byte
// RQ13: Clock reads start and advance own pointer
// RQ14: Memory and clock pointers are separate
// RQ15: Memory read resumes after clock accesses
// RQ16: Master always sends address in writes
// RQ17: Upper four bits pick memory or clock
// RQ18: Bits three to one match chip selects
// RQ19: Memory address two bytes, fifteen bits kept
// RQ20: Clock address uses low four bits
// RQ21: Ended read releases line, waits for Start
`timescale 1ns/100ps
`default_nettype none

module twr_dev (
	input  wire logic                        clock_i,
	input  wire logic                        nrst_i,
	input  wire logic                        ce_i,
	twr_if.slave                             bus,
	input  wire logic [2:0]                  chip_select_pins_i,
	output logic                             fetch_rtc_o,
	output logic [twr_pkg::MEM_AW-1:0]       fetch_addr_o,
	input  wire logic [7:0]                  fetch_data_i,
	output logic                             wr_stb_o,
	output logic                             wr_rtc_o,
	output logic [twr_pkg::MEM_AW-1:0]       wr_addr_o,
	output logic [7:0]                       wr_data_o,
	output logic                             busy_o
);
	import twr_pkg::*;

	logic [1:0]           scl_sync_reg;
	logic [1:0]           sda_sync_reg;
	logic                 scl_d_reg;
	logic                 sda_d_reg;
	logic [2:0]           cs_s1_reg;
	logic [2:0]           cs_s2_reg;
	twr_dev_state_t       state_reg;
	twr_dev_state_t       ack_next_reg;
	logic [3:0]           bit_reg;
	logic [7:0]           shin_reg;
	logic [7:0]           shout_reg;
	logic                 oe_reg;
	logic                 rtc_sel_reg;
	logic                 mack_reg;
	logic [6:0]           hi_reg;
	logic [MEM_AW-1:0]    mem_addr_reg;
	logic [RTC_AW-1:0]    rtc_addr_reg;
	logic                 wr_stb_reg;
	logic                 wr_rtc_reg;
	logic [MEM_AW-1:0]    wr_addr_reg;
	logic [7:0]           wr_data_reg;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage and its delay are decoded
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
			cs_s1_reg    <= 3'h0;
			cs_s2_reg    <= 3'h0;
		end else if (ce_i) begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
			cs_s1_reg    <= chip_select_pins_i;
			cs_s2_reg    <= cs_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line events and byte decode
	wire scl_s      = scl_sync_reg[1];
	wire sda_s      = sda_sync_reg[1];
	wire scl_rise   = scl_s & ~scl_d_reg;
	wire scl_fall   = ~scl_s & scl_d_reg;
	wire start_det  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire byte_done  = scl_fall & (bit_reg == BYTE_BITS);
	wire id_mem     = shin_reg[7:ID_LSB] == ID_MEM;              // [RQ17]
	wire id_rtc     = shin_reg[7:ID_LSB] == ID_RTC;              // [RQ17]
	wire cs_hit     = shin_reg[ID_LSB-1:CS_LSB] == cs_s2_reg;    // [RQ18]
	wire addr_hit   = (id_mem | id_rtc) & cs_hit;
	wire rd_req     = shin_reg[RW_BIT];
	wire recv_state = (state_reg == D_ADDR) | (state_reg == D_AHI) |
	                  (state_reg == D_ALO) | (state_reg == D_WDAT);
	wire sent_last  = scl_fall & (state_reg == D_RD) & (bit_reg == LAST_BIT);
	wire load_mem   = byte_done & (state_reg == D_ALO) & ~rtc_sel_reg;
	wire load_rtc   = byte_done & (state_reg == D_ALO) & rtc_sel_reg;
	wire step_addr  = sent_last | (byte_done & (state_reg == D_WDAT));
	wire [MEM_AW-1:0] cur_addr = rtc_sel_reg ?
	                  {{(MEM_AW-RTC_AW){1'b0}}, rtc_addr_reg} : mem_addr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Address pointers: each target keeps and advances only its own
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			mem_addr_reg <= MEM_RST;
			rtc_addr_reg <= RTC_RST;
		end else if (ce_i) begin
			if (load_mem)
				mem_addr_reg <= {hi_reg, shin_reg};                // [RQ19] [RQ10]
			else if (step_addr && !rtc_sel_reg)
				mem_addr_reg <= twr_mem_next(mem_addr_reg);        // [RQ3] [RQ9] [RQ14]
			if (load_rtc)
				rtc_addr_reg <= shin_reg[RTC_AW-1:0];              // [RQ20] [RQ12]
			else if (step_addr && rtc_sel_reg)
				rtc_addr_reg <= twr_rtc_next(rtc_addr_reg);        // [RQ13] [RQ14]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write byte hand-off; a byte only counts once its eighth bit is in
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wr_stb_reg  <= 1'b0;
			wr_rtc_reg  <= 1'b0;
			wr_addr_reg <= MEM_RST;
			wr_data_reg <= 8'h00;
		end else if (ce_i) begin
			wr_stb_reg <= byte_done & (state_reg == D_WDAT) & ~start_det & ~stop_det;
			if (byte_done && state_reg == D_WDAT) begin
				wr_rtc_reg  <= rtc_sel_reg;
				wr_addr_reg <= cur_addr;
				wr_data_reg <= shin_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequencer; Stop and Start override every state
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_reg    <= D_IDLE;
			ack_next_reg <= D_IDLE;
			bit_reg      <= 4'h0;
			shin_reg     <= 8'h00;
			shout_reg    <= 8'h00;
			oe_reg       <= 1'b0;
			rtc_sel_reg  <= 1'b0;
			mack_reg     <= 1'b0;
			hi_reg       <= 7'h00;
		end else if (ce_i) begin
			if (stop_det) begin
				state_reg <= D_IDLE;                               // [RQ5] [RQ7] [RQ21]
				oe_reg    <= 1'b0;
			end else if (start_det) begin
				state_reg <= D_ADDR;                               // [RQ6] [RQ7] [RQ11]
				bit_reg   <= 4'h0;
				oe_reg    <= 1'b0;
			end else if (recv_state && scl_rise) begin
				shin_reg <= {shin_reg[6:0], sda_s};
				bit_reg  <= bit_reg + 4'h1;
			end else if (recv_state && byte_done) begin
				bit_reg   <= 4'h0;
				state_reg <= D_ACK;
				oe_reg    <= 1'b1;
				unique case (state_reg)
					D_ADDR: begin
						oe_reg      <= addr_hit;
						state_reg   <= addr_hit ? D_ACK : D_IDLE;
						rtc_sel_reg <= id_rtc;
						// Clock target skips the upper address byte
						ack_next_reg <= rd_req ? D_RD : (id_rtc ? D_ALO : D_AHI); // [RQ12]
					end
					D_AHI: begin
						hi_reg       <= shin_reg[6:0];             // [RQ19]
						ack_next_reg <= D_ALO;
					end
					default: ack_next_reg <= D_WDAT;
				endcase
			end else if (scl_fall) begin
				unique case (state_reg)
					D_ACK: begin
						// First data bit goes out on the fall after the ack
						state_reg <= ack_next_reg;
						bit_reg   <= 4'h0;
						shout_reg <= fetch_data_i;                 // [RQ1] [RQ2] [RQ13] [RQ15]
						oe_reg    <= (ack_next_reg == D_RD) & ~fetch_data_i[7];
					end
					D_RD: begin
						if (bit_reg == LAST_BIT) begin
							state_reg <= D_RACK;                   // [RQ3]
							oe_reg    <= 1'b0;
						end else begin
							bit_reg   <= bit_reg + 4'h1;
							oe_reg    <= ~shout_reg[6];
							shout_reg <= {shout_reg[6:0], 1'b0};
						end
					end
					D_RACK: begin
						// An ack commits to the next byte even if the master
						// meant to stop: it then fights the master on the line
						bit_reg   <= 4'h0;
						state_reg <= mack_reg ? D_RD : D_IDLE;     // [RQ4] [RQ8] [RQ21]
						shout_reg <= fetch_data_i;
						oe_reg    <= mack_reg & ~fetch_data_i[7];
					end
					default: state_reg <= state_reg;
				endcase
			end else if (state_reg == D_RACK && scl_rise) begin
				mack_reg <= ~sda_s;                                // [RQ4]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = oe_reg;
	assign fetch_rtc_o  = rtc_sel_reg;
	assign fetch_addr_o = cur_addr;
	assign wr_stb_o     = wr_stb_reg;
	assign wr_rtc_o     = wr_rtc_reg;
	assign wr_addr_o    = wr_addr_reg;
	assign wr_data_o    = wr_data_reg;
	assign busy_o       = state_reg != D_IDLE;

endmodule : twr_dev

`default_nettype wire

// file: hw/twr_host.sv
// Bus master end: makes the link clock by division, runs current and
// selective reads, ends them in any of the four ways, buffers read bytes.
// Assumes a single master on the link and the slave on the same interface.
`timescale 1ns/100ps
`default_nettype none

module twr_host (
	input  wire logic                        clock_i,
	input  wire logic                        nrst_i,
	input  wire logic                        ce_i,
	twr_if.master                            bus,
	input  wire logic                        cmd_valid_i,
	output logic                             cmd_ready_o,
	input  wire logic                        cmd_sel_i,
	input  wire logic                        cmd_rtc_i,
	input  wire logic [2:0]                  cmd_cs_i,
	input  wire logic [twr_pkg::MEM_AW-1:0]  cmd_addr_i,
	input  wire logic [7:0]                  cmd_len_i,
	input  wire twr_pkg::twr_term_t          cmd_end_i,
	output logic                             rx_valid_o,
	input  wire logic                        rx_ready_i,
	output logic [7:0]                       rx_data_o,
	output logic                             done_o,
	output logic                             nack_o
);
	import twr_pkg::*;

	twr_host_state_t    state_reg;
	twr_phase_t         ph_reg;
	twr_term_t          end_reg;
	logic [2:0]         cnt_reg;
	logic [3:0]         bit_reg;
	logic [7:0]         sh_reg;
	logic [7:0]         left_reg;
	logic               sel_reg;
	logic               rtc_reg;
	logic [2:0]         cs_reg;
	logic [MEM_AW-1:0]  addr_reg;
	logic               sent_reg;
	logic               trail_reg;
	logic               done_reg;
	logic               nack_reg;
	logic [1:0]         sda_sync_reg;
	logic [7:0]         fifo_reg [0:1];
	logic               wp_reg;
	logic               rp_reg;
	logic [1:0]         fcnt_reg;

	////////////////////////////////////////////////////////////////////////////
	// Slot decode: four quarters of one link clock period
	wire [1:0] quarter   = cnt_reg[2:1];
	wire       slot_end  = cnt_reg == SLOT_LAST;
	wire       sda_s     = sda_sync_reg[1];
	wire       fifo_full = fcnt_reg == FIFO_DEPTH;
	wire       push      = slot_end & (state_reg == H_RX) & (bit_reg == LAST_BIT);
	wire       pop       = rx_valid_o & rx_ready_i;
	wire       last_byte = left_reg == 8'h01;
	wire       stall     = (state_reg == H_RX) & (bit_reg == 4'h0) & (cnt_reg == 3'h0) & fifo_full;
	// Start raises the clock late: the slave's ack release must not look like a Stop
	wire       cond_slot = state_reg == H_STOP;
	wire [7:0] slave_hdr = {(rtc_reg ? ID_RTC : ID_MEM), cs_reg, 1'b0};
	wire [7:0] rx_byte   = {sh_reg[6:0], sda_s};

	// Line drive: start pulls low late in its slot, stop releases late
	wire drv_low = (state_reg == H_START) ? (quarter == 2'h3) :
	               (state_reg == H_STOP)  ? ~quarter[1] :
	               (state_reg == H_TX)    ? (bit_reg != BYTE_BITS) & ~sh_reg[7] :
	               (state_reg == H_RX)    ? (bit_reg == BYTE_BITS) & ~last_byte : // [RQ4] [RQ5]
	               1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Two-entry read buffer; a full buffer holds the clock low
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wp_reg   <= 1'b0;
			rp_reg   <= 1'b0;
			fcnt_reg <= 2'h0;
		end else if (ce_i) begin
			if (push)
				fifo_reg[wp_reg] <= rx_byte;
			wp_reg   <= wp_reg ^ push;
			rp_reg   <= rp_reg ^ pop;
			fcnt_reg <= fcnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_reg <= H_IDLE;
			ph_reg    <= P_SW;
			end_reg   <= T_NACK_STOP;
			cnt_reg   <= 3'h0;
			bit_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			left_reg  <= 8'h00;
			sel_reg   <= 1'b0;
			rtc_reg   <= 1'b0;
			cs_reg    <= 3'h0;
			addr_reg  <= MEM_RST;
			sent_reg  <= 1'b0;
			trail_reg <= 1'b0;
			done_reg  <= 1'b0;
			nack_reg  <= 1'b0;
			sda_sync_reg <= 2'h3;
		end else if (ce_i) begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			if (state_reg != H_IDLE && !stall)
				cnt_reg <= cnt_reg + 3'h1;
			unique case (state_reg)
				H_IDLE: if (cmd_valid_i) begin
					state_reg <= H_START;
					cnt_reg   <= 3'h0;
					sel_reg   <= cmd_sel_i;
					rtc_reg   <= cmd_rtc_i;
					cs_reg    <= cmd_cs_i;
					addr_reg  <= cmd_addr_i;
					end_reg   <= cmd_end_i;
					left_reg  <= (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
					sent_reg  <= 1'b0;
					trail_reg <= 1'b0;
				end
				H_START: if (slot_end) begin
					// Selective read writes the address, then restarts as read
					bit_reg   <= 4'h0;
					state_reg <= trail_reg ? H_STOP : H_TX;
					ph_reg    <= (sel_reg && !sent_reg) ? P_SW : P_SR;
					sh_reg    <= slave_hdr | {7'h00, ~(sel_reg & ~sent_reg)};
				end
				H_TX: if (slot_end) begin
					if (bit_reg != BYTE_BITS) begin
						bit_reg <= bit_reg + 4'h1;
						sh_reg  <= {sh_reg[6:0], 1'b0};
					end else if (sda_s) begin
						nack_reg  <= 1'b1;
						state_reg <= H_STOP;
					end else begin
						bit_reg <= 4'h0;
						unique case (ph_reg)
							P_SW: begin
								ph_reg <= rtc_reg ? P_ALO : P_AHI;      // [RQ10] [RQ16]
								sh_reg <= rtc_reg ? addr_reg[7:0] : {1'b0, addr_reg[14:8]};
							end
							P_AHI: begin
								ph_reg <= P_ALO;
								sh_reg <= addr_reg[7:0];
							end
							P_ALO: begin
								sent_reg  <= 1'b1;
								state_reg <= H_START;                  // [RQ11]
							end
							P_SR: begin
								ph_reg    <= P_RX;
								state_reg <= H_RX;
							end
							default: state_reg <= H_STOP;
						endcase
					end
				end
				H_RX: if (slot_end) begin
					sh_reg  <= rx_byte;
					bit_reg <= bit_reg + 4'h1;
					if (bit_reg == LAST_BIT && last_byte && end_reg == T_STOP9)
						state_reg <= H_STOP;                           // [RQ7]
					else if (bit_reg == LAST_BIT && last_byte && end_reg == T_START9) begin
						state_reg <= H_START;                          // [RQ7]
						trail_reg <= 1'b1;
					end else if (bit_reg == BYTE_BITS) begin
						bit_reg  <= 4'h0;
						left_reg <= left_reg - 8'h01;
						if (last_byte) begin
							state_reg <= (end_reg == T_NACK_START) ? H_START : H_STOP; // [RQ5] [RQ6]
							trail_reg <= 1'b1;
						end
					end
				end
				H_STOP: if (slot_end) begin
					state_reg <= H_IDLE;
					done_reg  <= 1'b1;
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs; clock rises in quarter 2 for bits and Starts, quarter 1 for Stops
	assign bus.scl      = (state_reg == H_IDLE) | (cond_slot ? (quarter != 2'h0) : quarter[1]);
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = drv_low;
	assign cmd_ready_o  = state_reg == H_IDLE;
	assign rx_valid_o   = fcnt_reg != 2'h0;
	assign rx_data_o    = fifo_reg[rp_reg];
	assign done_o       = done_reg;
	assign nack_o       = nack_reg;

endmodule : twr_host

`default_nettype wire

// file: test/twr_link_monitor.sv
// Checker for the serial link between the master and slave ends.
// Assumes every link signal changes just after a rising edge of clock_i.
`timescale 1ns/100ps
`default_nettype none

module twr_link_monitor (
	input  wire logic clock_i,
	input  wire logic nrst_i,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic s_sda_o,
	input  wire logic s_sda_oe
);
	logic       scl_reg, sda_reg, hdr_reg, idle_reg;
	logic [3:0] cnt_reg, gap_reg;
	wire        start_w = scl & scl_reg & sda_reg & ~sda;
	wire        stop_w  = scl & scl_reg & ~sda_reg & sda;
	wire        rise_w  = scl & ~scl_reg;

	////////////////////////////////////////////////////////////////////////////
	// Header bit count and quiet time after a Stop; counters saturate
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			{scl_reg, sda_reg, hdr_reg, idle_reg} <= 4'hd;
			cnt_reg <= 4'h0;
			gap_reg <= 4'h0;
		end else begin
			scl_reg  <= scl;
			sda_reg  <= sda;
			hdr_reg  <= start_w | (hdr_reg & ~stop_w & ~(rise_w & (cnt_reg == 4'h8)));
			cnt_reg  <= start_w ? 4'h0 : cnt_reg + {3'h0, rise_w & (cnt_reg != 4'hf)};
			idle_reg <= stop_w | (idle_reg & ~start_w);
			gap_reg  <= stop_w ? 4'h0 : gap_reg + {3'h0, gap_reg != 4'hf};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link properties
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	property p_od_slave; s_sda_o == 1'b0; endproperty
	a_od_slave: assert property (p_od_slave)
		else $error("slave data drive value not low");
	property p_hdr_quiet; hdr_reg && cnt_reg != 4'h0 && cnt_reg < 4'h8 |-> !s_sda_oe; endproperty
	a_hdr_quiet: assert property (p_hdr_quiet)
		else $error("slave drives during slave address bits");
	property p_rel_stop; stop_w |-> ##[0:4] !s_sda_oe; endproperty
	a_rel_stop: assert property (p_rel_stop)
		else $error("slave holds data line after Stop");
	property p_idle_quiet; idle_reg && gap_reg > 4'h5 |-> !s_sda_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("slave drives while bus idle");
	property p_rel_start; start_w |-> ##[0:4] !s_sda_oe; endproperty
	a_rel_start: assert property (p_rel_start)
		else $error("slave holds data line after Start");
	property p_oe_rise; $rose(s_sda_oe) |-> !scl; endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("slave starts driving while clock high");
	property p_scl_high; $rose(scl) |-> scl[*4]; endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("link clock high phase too short");
	property p_scl_low; $fell(scl) |-> !scl[*2]; endproperty
	a_scl_low: assert property (p_scl_low)
		else $error("link clock low phase too short");

	c_start: cover property (start_w);
	c_stop:  cover property (stop_w);
	c_drive: cover property ($rose(s_sda_oe) && !hdr_reg);
endmodule : twr_link_monitor

`default_nettype wire

// file: test/tb_top.sv
// Bench joining master and slave ends; random and corner reads checked.
// Assumes the slave's fetch data comes from a bench content function.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import twr_pkg::*;
	localparam logic [2:0] CS = 3'h5;
	logic        clock_i, nrst_i, cmd_valid_i, cmd_sel_i, cmd_rtc_i, rx_ready_i;
	logic        got_done, got_nack;
	logic [2:0]  cmd_cs_i;
	logic [14:0] cmd_addr_i, mp, rp;
	logic [7:0]  cmd_len_i, fetch_data_i;
	logic [31:0] r;
	twr_term_t   cmd_end_i;
	wire         cmd_ready_o, rx_valid_o, done_o, nack_o, fetch_rtc_o, wr_stb_o, busy_o;
	wire [14:0]  fetch_addr_o;
	wire [7:0]   rx_data_o;
	int          miscompares = 0, checked = 0, cycles = 0, stall_end = 0, seed;
	logic [7:0]  rxq[$];

	twr_if lnk ();
	twr_dev i_twr_dev (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1), .bus(lnk.slave),
		.chip_select_pins_i(CS), .fetch_rtc_o(fetch_rtc_o), .fetch_addr_o(fetch_addr_o),
		.fetch_data_i(fetch_data_i), .wr_stb_o(wr_stb_o), .wr_rtc_o(), .wr_addr_o(),
		.wr_data_o(), .busy_o(busy_o));
	twr_host i_twr_host (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1), .bus(lnk.master),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_sel_i(cmd_sel_i),
		.cmd_rtc_i(cmd_rtc_i),
		.cmd_cs_i(cmd_cs_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
		.cmd_end_i(cmd_end_i), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
		.rx_data_o(rx_data_o), .done_o(done_o), .nack_o(nack_o));
	twr_link_monitor i_twr_link_monitor (.clock_i(clock_i), .nrst_i(nrst_i), .scl(lnk.scl),
		.sda(lnk.sda), .s_sda_o(lnk.s_sda_o), .s_sda_oe(lnk.s_sda_oe));

	////////////////////////////////////////////////////////////////////////////
	// Content of both targets; clock bytes distinct per address, memory bytes fold the high address byte into the low
	function automatic logic [7:0] byte_at(input logic rtc, input logic [14:0] a);
		byte_at = rtc ? 8'h50 + {4'h0, a[3:0]} : a[7:0] ^ {1'b0, a[14:8]};
	endfunction : byte_at
	assign fetch_data_i = byte_at(fetch_rtc_o, fetch_addr_o);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results

	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver with random stalls, event capture and the hang limit
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (rx_valid_o && rx_ready_i) rxq.push_back(rx_data_o);
		if (done_o) got_done <= 1'b1;
		if (nack_o) got_nack <= 1'b1;
		rx_ready_i <= (cycles > stall_end) && (($random(seed) & 3) == 0);
		if (nrst_i && wr_stb_o !== 1'b0) check("write strobe", 16'(wr_stb_o), 16'h0);
		if (cycles == 60000) begin
			miscompares++;
			results();
		end
	end

	// One command; expected bytes follow the bench's own pointer copies
	task automatic run(input logic sel, rtc, input logic [2:0] cs, input logic [14:0] a,
		input logic [7:0] len, input twr_term_t term);
		int  n;
		logic ok;
		ok = (cs == CS);
		n = ok ? ((len == 8'h0) ? 1 : len) : 0;
		if (ok && sel && rtc) rp = {11'h0, a[3:0]};
		if (ok && sel && !rtc) mp = a;
		rxq.delete();
		got_done = 1'b0;
		got_nack = 1'b0;
		@(posedge clock_i);
		{cmd_valid_i, cmd_sel_i, cmd_rtc_i, cmd_cs_i} <= {1'b1, sel, rtc, cs};
		{cmd_addr_i, cmd_len_i, cmd_end_i} <= {a, len, term};
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
		while (got_done !== 1'b1 || rx_valid_o !== 1'b0) begin
			@(posedge clock_i);
			#1;
		end
		check("no acknowledge", 16'(got_nack), 16'(!ok));
		check("slave idle", 16'(busy_o), 16'h0);
		check("command ready", 16'(cmd_ready_o), 16'h1);
		check("byte count", 16'(rxq.size()), 16'(n));
		for (int i = 0; i < n; i++) begin
			check("read byte", 16'(rxq[i]), 16'(byte_at(rtc, rtc ? rp : mp)));
			if (rtc) rp = (rp >= 15'h8) ? 15'h0 : rp + 15'h1;
			else mp = mp + 15'h1;
		end
	endtask : run

	////////////////////////////////////////////////////////////////////////////
	// Corner cases first, then random commands
	initial begin
		seed = 32'h3d798d03;
		{nrst_i, cmd_valid_i, cmd_sel_i, cmd_rtc_i, cmd_cs_i, rx_ready_i} = 8'h00;
		{cmd_addr_i, cmd_len_i, mp, rp} = 53'h0;
		cmd_end_i = T_NACK_STOP;
		repeat (3) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		#1;
		check("reset drive", 16'(lnk.s_sda_oe), 16'h0);
		check("reset busy", 16'(busy_o), 16'h0);
		check("reset ready", 16'(cmd_ready_o), 16'h1);
		run(1'b1, 1'b0, CS, 15'h7ffe, 8'h4, T_NACK_STOP);
		run(1'b0, 1'b0, CS, 15'h0, 8'h3, T_NACK_START);
		run(1'b1, 1'b1, CS, 15'h00f7, 8'h3, T_STOP9);
		run(1'b0, 1'b0, CS, 15'h0, 8'h2, T_START9);
		run(1'b1, 1'b0, CS ^ 3'h1, 15'h1234, 8'h2, T_NACK_STOP);
		stall_end = cycles + 600;
		run(1'b0, 1'b1, CS, 15'h0, 8'h6, T_NACK_STOP);
		for (int k = 0; k < 14; k++) begin
			r = $random(seed);
			run(r[0], r[1], (r[4:2] == 3'h0) ? r[7:5] : CS,
				r[1] ? {11'h0, 4'(r[19:16] % 9)} : r[30:16], {5'h0, r[10:8]},
				twr_term_t'(r[12:11]));
		end
		results();
	end
endmodule : tb_top

`default_nettype wire
